// >>> pkg/dmacr_map.vh
// register map, field positions and reset values of the dma counter block
// Notes on behaviour
// - block byte count is 16 bits over two byte registers, high byte bits 15..8.
// - block byte count resets to one, not zero.
// - a zero count written then triggered moves 0xffff bytes.
// - count drops after each byte read, reloads last written value at zero.
// - repeat counter at channel offset 0x06 drops once per finished block.
// - repeat mode, nonzero count: channel disables when count hits zero after block.
// - repeat mode with repeat counter written zero repeats blocks without limit.
// - 24-bit source pointer at channel offsets 0x08..0x0a, top offset most significant.
// - source pointer steps up, down or holds per source direction field.
// - 24-bit dest pointer at channel offsets 0x0c..0x0e, top offset most significant.
// - dest pointer steps up, down or holds per dest direction field.
// - multi-byte registers go through shadow bytes so updates stay coherent.
// - channel blocks sit at controller offsets 0x10, 0x20, 0x30, 0x40.
`ifndef DMACR_MAP_VH
`define DMACR_MAP_VH
`define DMACR_IDX_CTRL 4'h0
`define DMACR_IDX_FLAGS 4'h3
`define DMACR_IDX_STATE 4'h4
`define DMACR_IDX_SHL 4'h6
`define DMACR_IDX_SHH 4'h7
`define DMACR_CH_FIRST 4'h1
`define DMACR_CH_LAST 4'h4
`define DMACR_CH_CTLA 4'h0
`define DMACR_CH_CTLB 4'h1
`define DMACR_CH_PTRC 4'h2
`define DMACR_CH_TRIG 4'h3
`define DMACR_CH_CNTL 4'h4
`define DMACR_CH_CNTH 4'h5
`define DMACR_CH_REP 4'h6
`define DMACR_CH_SRC0 4'h8
`define DMACR_CH_SRC1 4'h9
`define DMACR_CH_SRC2 4'ha
`define DMACR_CH_DST0 4'hc
`define DMACR_CH_DST1 4'hd
`define DMACR_CH_DST2 4'he
`define DMACR_BIT_EN 7
`define DMACR_BIT_RST 6
`define DMACR_BIT_REP 5
`define DMACR_BIT_SWREQ 4
`define DMACR_BIT_ERRF 5
`define DMACR_BIT_DONEF 4
`define DMACR_SDIR_HI 5
`define DMACR_SDIR_LO 4
`define DMACR_DDIR_HI 1
`define DMACR_DDIR_LO 0
`define DMACR_DIR_HOLD 2'h0
`define DMACR_DIR_INC 2'h1
`define DMACR_DIR_DEC 2'h2
`define DMACR_CNT_RST 16'h0001
`define DMACR_CNT_ZERO_RUN 16'hffff
`endif

// >>> rtl/dmacr_regs.v
// four channel dma counter, pointer and register block with apb slave
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`include "dmacr_map.vh"
module dmacr_regs #(
    parameter DW = 8
) (
    // clock, reset, enable
    input wire pclk,
    input wire presetn,
    input wire ce,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // triggers from same-clock peripherals
    input wire [3:0] trig_in,
    // source read port
    output wire src_req,
    output wire [23:0] src_addr,
    input wire src_ready,
    input wire src_err,
    input wire [DW-1:0] src_rdata,
    // destination write port
    output wire dst_valid,
    output wire [23:0] dst_addr,
    output wire [DW-1:0] dst_data,
    input wire dst_ready
);
    reg [7:0] ctrl_q;
    reg [7:0] flg_q;
    reg [7:0] shl_q;
    reg [7:0] shh_q;
    reg [7:0] cta_q [0:3];
    reg [3:0] lvl_q [0:3];
    reg [7:0] ptc_q [0:3];
    reg [7:0] tsel_q [0:3];
    reg [15:0] cnt_q [0:3];
    reg [15:0] last_q [0:3];
    reg [7:0] rep_q [0:3];
    reg [3:0] rlim_q;
    reg [23:0] src_q [0:3];
    reg [23:0] dst_q [0:3];
    reg [3:0] pend_q;
    reg run_q;
    reg rdone_q;
    reg [1:0] act_q;
    // two-entry data buffer
    reg [DW-1:0] buf_q [0:1];
    reg buf_wp_q;
    reg buf_rp_q;
    reg [1:0] buf_n_q;

    reg [7:0] rd_d;
    reg pslverr_d;
    reg [1:0] pick_d;
    reg pick_ok_d;
    integer k;
    integer p;

    wire [7:0] idx = paddr[9:2];
    wire [3:0] blk = idx[7:4];
    wire [3:0] off = idx[3:0];
    wire ch_hit = (blk >= `DMACR_CH_FIRST) && (blk <= `DMACR_CH_LAST);
    wire [1:0] ch = idx[5:4] - 2'd1;
    wire acc = psel && penable && !pready;
    wire wr = acc && pwrite && !pslverr_d;
    wire rd = acc && !pwrite && !pslverr_d;
    wire [7:0] wd = pwdata[7:0];

    wire buf_in_rdy = (buf_n_q != 2'd2);
    wire buf_out_vld = (buf_n_q != 2'd0);
    assign src_req = run_q && !rdone_q && buf_in_rdy;
    assign src_addr = src_q[act_q];
    assign dst_valid = buf_out_vld;
    assign dst_addr = dst_q[act_q];
    assign dst_data = buf_q[buf_rp_q];
    wire push = src_req && src_ready && !src_err;
    wire pop = dst_valid && dst_ready;
    wire blk_end = run_q && rdone_q && !buf_out_vld;

    // read mux and address decode
    always @* begin
        rd_d = 8'h00;
        pslverr_d = 1'b0;
        if (blk == 4'h0) begin
            case (off)
                `DMACR_IDX_CTRL: rd_d = ctrl_q;
                `DMACR_IDX_FLAGS: rd_d = flg_q;
                `DMACR_IDX_STATE: rd_d = {run_q && (act_q == 2'd3), run_q && (act_q == 2'd2),
                                          run_q && (act_q == 2'd1), run_q && (act_q == 2'd0), pend_q};
                `DMACR_IDX_SHL: rd_d = shl_q;
                `DMACR_IDX_SHH: rd_d = shh_q;
                default: pslverr_d = 1'b1;
            endcase
        end else if (ch_hit) begin
            case (off)
                `DMACR_CH_CTLA: rd_d = cta_q[ch];
                `DMACR_CH_CTLB: rd_d = {run_q && (act_q == ch), pend_q[ch], flg_q[ch + 3'd4], flg_q[ch], lvl_q[ch]};
                `DMACR_CH_PTRC: rd_d = ptc_q[ch];
                `DMACR_CH_TRIG: rd_d = tsel_q[ch];
                `DMACR_CH_CNTL: rd_d = cnt_q[ch][7:0];
                `DMACR_CH_CNTH: rd_d = shh_q;
                `DMACR_CH_REP: rd_d = rep_q[ch];
                `DMACR_CH_SRC0: rd_d = src_q[ch][7:0];
                `DMACR_CH_SRC1: rd_d = shl_q;
                `DMACR_CH_SRC2: rd_d = shh_q;
                `DMACR_CH_DST0: rd_d = dst_q[ch][7:0];
                `DMACR_CH_DST1: rd_d = shl_q;
                `DMACR_CH_DST2: rd_d = shh_q;
                default: pslverr_d = 1'b1;
            endcase
        end else begin
            pslverr_d = 1'b1;
        end
    end

    // lowest pending enabled channel wins
    always @* begin
        pick_d = 2'd0;
        pick_ok_d = 1'b0;
        for (p = 3; p >= 0; p = p - 1) begin
            if (pend_q[p] && cta_q[p][`DMACR_BIT_EN]) begin
                pick_d = p[1:0];
                pick_ok_d = 1'b1;
            end
        end
    end

    // apb answer, one wait cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            if (acc) begin
                prdata <= pwrite ? 32'h00000000 : {24'h000000, rd_d};
                pslverr <= pslverr_d;
                pready <= 1'b1;
            end else begin
                pready <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    // two-entry buffer between source reads and destination writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_wp_q <= 1'b0;
            buf_rp_q <= 1'b0;
            buf_n_q <= 2'd0;
            buf_q[0] <= {DW{1'b0}};
            buf_q[1] <= {DW{1'b0}};
        end else if (ce) begin
            if (push) begin
                buf_q[buf_wp_q] <= src_rdata;
                buf_wp_q <= ~buf_wp_q;
            end
            if (pop)
                buf_rp_q <= ~buf_rp_q;
            if (push && !pop)
                buf_n_q <= buf_n_q + 2'd1;
            else if (pop && !push)
                buf_n_q <= buf_n_q - 2'd1;
        end
    end

    // channel registers and transfer engine
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 8'h00;
            flg_q <= 8'h00;
            shl_q <= 8'h00;
            shh_q <= 8'h00;
            pend_q <= 4'h0;
            rlim_q <= 4'h0;
            run_q <= 1'b0;
            rdone_q <= 1'b0;
            act_q <= 2'd0;
            for (k = 0; k < 4; k = k + 1) begin
                cta_q[k] <= 8'h00;
                lvl_q[k] <= 4'h0;
                ptc_q[k] <= 8'h00;
                tsel_q[k] <= 8'h00;
                cnt_q[k] <= `DMACR_CNT_RST;
                last_q[k] <= `DMACR_CNT_RST;
                rep_q[k] <= 8'h00;
                src_q[k] <= 24'h000000;
                dst_q[k] <= 24'h000000;
            end
        end else if (ce) begin
            // triggers
            for (k = 0; k < 4; k = k + 1) begin
                if (trig_in[k] && (tsel_q[k] != 8'h00) && cta_q[k][`DMACR_BIT_EN])
                    pend_q[k] <= 1'b1;
            end
            // start a block
            if (!run_q && !buf_out_vld && pick_ok_d && ctrl_q[`DMACR_BIT_EN]) begin
                run_q <= 1'b1;
                act_q <= pick_d;
                pend_q[pick_d] <= 1'b0;
                if (cnt_q[pick_d] == 16'h0000)
                    cnt_q[pick_d] <= `DMACR_CNT_ZERO_RUN;
            end
            // byte read
            if (push) begin
                cnt_q[act_q] <= cnt_q[act_q] - 16'd1;
                if (cnt_q[act_q] == 16'd1) begin
                    cnt_q[act_q] <= last_q[act_q];
                    rdone_q <= 1'b1;
                end
                case (ptc_q[act_q][`DMACR_SDIR_HI:`DMACR_SDIR_LO])
                    `DMACR_DIR_INC: src_q[act_q] <= src_q[act_q] + 24'd1;
                    `DMACR_DIR_DEC: src_q[act_q] <= src_q[act_q] - 24'd1;
                    default: src_q[act_q] <= src_q[act_q];
                endcase
            end
            // byte write
            if (pop) begin
                case (ptc_q[act_q][`DMACR_DDIR_HI:`DMACR_DDIR_LO])
                    `DMACR_DIR_INC: dst_q[act_q] <= dst_q[act_q] + 24'd1;
                    `DMACR_DIR_DEC: dst_q[act_q] <= dst_q[act_q] - 24'd1;
                    default: dst_q[act_q] <= dst_q[act_q];
                endcase
            end
            // read error aborts the block and disables the channel
            if (run_q && src_req && src_err) begin
                run_q <= 1'b0;
                rdone_q <= 1'b0;
                cnt_q[act_q] <= last_q[act_q];
                cta_q[act_q][`DMACR_BIT_EN] <= 1'b0;
            end
            // block finished
            if (blk_end) begin
                run_q <= 1'b0;
                rdone_q <= 1'b0;
                if (rep_q[act_q] != 8'h00)
                    rep_q[act_q] <= rep_q[act_q] - 8'd1;
                if (!cta_q[act_q][`DMACR_BIT_REP])
                    cta_q[act_q][`DMACR_BIT_EN] <= 1'b0;
                else if (rlim_q[act_q] && (rep_q[act_q] <= 8'd1))
                    cta_q[act_q][`DMACR_BIT_EN] <= 1'b0;
            end
            // shadow capture on low-byte reads
            if (rd && ch_hit) begin
                case (off)
                    `DMACR_CH_CNTL: shh_q <= cnt_q[ch][15:8];
                    `DMACR_CH_SRC0: {shh_q, shl_q} <= src_q[ch][23:8];
                    `DMACR_CH_DST0: {shh_q, shl_q} <= dst_q[ch][23:8];
                    default: shl_q <= shl_q;
                endcase
            end
            // register writes
            if (wr && (blk == 4'h0)) begin
                case (off)
                    `DMACR_IDX_CTRL: ctrl_q <= wd;
                    `DMACR_IDX_FLAGS: flg_q <= flg_q & ~wd;
                    `DMACR_IDX_SHL: shl_q <= wd;
                    `DMACR_IDX_SHH: shh_q <= wd;
                    default: ctrl_q <= ctrl_q;
                endcase
            end
            if (wr && ch_hit) begin
                case (off)
                    `DMACR_CH_CTLA: begin
                        cta_q[ch] <= {wd[7:5], 1'b0, wd[3:0]};
                        if (wd[`DMACR_BIT_SWREQ] && wd[`DMACR_BIT_EN])
                            pend_q[ch] <= 1'b1;
                    end
                    `DMACR_CH_CTLB: begin
                        lvl_q[ch] <= wd[3:0];
                        if (wd[`DMACR_BIT_ERRF])
                            flg_q[ch + 3'd4] <= 1'b0;
                        if (wd[`DMACR_BIT_DONEF])
                            flg_q[ch] <= 1'b0;
                    end
                    `DMACR_CH_PTRC: ptc_q[ch] <= wd;
                    `DMACR_CH_TRIG: tsel_q[ch] <= wd;
                    `DMACR_CH_CNTL: shl_q <= wd;
                    `DMACR_CH_CNTH: begin
                        cnt_q[ch] <= {wd, shl_q};
                        last_q[ch] <= {wd, shl_q};
                    end
                    `DMACR_CH_REP: begin
                        rep_q[ch] <= wd;
                        rlim_q[ch] <= (wd != 8'h00);
                    end
                    `DMACR_CH_SRC0: shl_q <= wd;
                    `DMACR_CH_SRC1: shh_q <= wd;
                    `DMACR_CH_SRC2: src_q[ch] <= {wd, shh_q, shl_q};
                    `DMACR_CH_DST0: shl_q <= wd;
                    `DMACR_CH_DST1: shh_q <= wd;
                    `DMACR_CH_DST2: dst_q[ch] <= {wd, shh_q, shl_q};
                    default: shl_q <= shl_q;
                endcase
            end
            // flags set after clears so a same-cycle event wins
            if (blk_end)
                flg_q[act_q] <= 1'b1;
            if (run_q && src_req && src_err)
                flg_q[{1'b1, act_q}] <= 1'b1;
            // controller soft reset of all channels
            if (ctrl_q[`DMACR_BIT_RST]) begin
                ctrl_q[`DMACR_BIT_RST] <= 1'b0;
                pend_q <= 4'h0;
                run_q <= 1'b0;
                rdone_q <= 1'b0;
                for (k = 0; k < 4; k = k + 1) begin
                    cta_q[k] <= 8'h00;
                    cnt_q[k] <= `DMACR_CNT_RST;
                    last_q[k] <= `DMACR_CNT_RST;
                    rep_q[k] <= 8'h00;
                end
            end
        end
    end
endmodule

// >>> bench/dmacr_props_properties.sv
// port assertions for the dma counter block
`timescale 1ns/1ps
module dmacr_props #(
    parameter DW = 8
) (
    // clock, reset, apb
    input wire pclk, input wire presetn, input wire ce, input wire psel, input wire penable,
    input wire pwrite, input wire [11:0] paddr, input wire [31:0] pwdata, input wire [31:0] prdata,
    input wire pready, input wire pslverr, input wire [3:0] trig_in,
    // read and write ports
    input wire src_req, input wire [23:0] src_addr, input wire src_ready, input wire src_err,
    input wire [DW-1:0] src_rdata, input wire dst_valid, input wire [23:0] dst_addr,
    input wire [DW-1:0] dst_data, input wire dst_ready
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence apb_take; psel && penable && !pready && ce; endsequence
    sequence src_take; src_req && src_ready && !src_err && ce; endsequence
    sequence dst_take; dst_valid && dst_ready && ce; endsequence
    apb_answer_a: assert property (apb_take |=> pready)
        else $error("apb answer missing");
    apb_pulse_a: assert property (pready && ce |=> !pready)
        else $error("pready longer than one cycle");
    apb_cause_a: assert property ($rose(pready) |-> $past(psel && penable))
        else $error("pready without request");
    write_zero_a: assert property (pready && pwrite |-> prdata == 32'h0)
        else $error("read data on write");
    unmapped_err_a: assert property (apb_take ##0 paddr[9:2] inside {8'h05, 8'h17} |=> pslverr)
        else $error("reserved index not refused");
    repeat_map_a: assert property (apb_take ##0 paddr[9:2] == 8'h16 |=> !pslverr)
        else $error("repeat counter refused");
    src_step_a: assert property (src_take |=> src_addr - $past(src_addr) inside {24'h0, 24'h1, 24'hffffff})
        else $error("source pointer jumped");
    dst_step_a: assert property (dst_take |=> dst_addr - $past(dst_addr) inside {24'h0, 24'h1, 24'hffffff})
        else $error("dest pointer jumped");
    dst_hold_a: assert property (dst_valid && !dst_ready && ce |=> dst_valid && $stable(dst_data) && $stable(dst_addr))
        else $error("write dropped while stalled");
    err_stop_a: assert property (src_req && src_ready && src_err |-> ##[1:4] !src_req)
        else $error("reads go on after error");
endmodule
bind dmacr_regs dmacr_props #(.DW(DW)) u_props (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .trig_in(trig_in),
    .src_req(src_req), .src_addr(src_addr), .src_ready(src_ready), .src_err(src_err), .src_rdata(src_rdata),
    .dst_valid(dst_valid), .dst_addr(dst_addr), .dst_data(dst_data), .dst_ready(dst_ready));

// >>> bench/dmacr_mem.sv
// far side memory and write sink for the dma block
`timescale 1ns/1ps
module dmacr_mem (
    // clock, reset, mode
    input wire pclk, input wire presetn, input wire slow, input wire [15:0] err_at,
    // read port
    input wire src_req, input wire [23:0] src_addr,
    output reg src_ready, output reg src_err, output reg [7:0] src_rdata,
    // write port
    input wire dst_valid, input wire [23:0] dst_addr, input wire [7:0] dst_data,
    output reg dst_ready
);
    integer rd_n, wr_n, fill_max;
    reg [1:0] ph_q;
    reg [23:0] wa [0:7];
    reg [7:0] wd [0:7];
    always @* begin
        src_ready = src_req && (!slow || ph_q[0]);
        src_err = src_ready && (rd_n + 1 == err_at);
        src_rdata = src_addr[7:0] ^ src_addr[15:8] ^ 8'h3c;
        if (!src_ready) begin
            src_rdata = ~src_rdata ^ {6'h0, ph_q};
        end
        dst_ready = !slow || ph_q == 2'h3;
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_n <= 0;
            wr_n <= 0;
            fill_max <= 0;
            ph_q <= 2'h0;
        end else begin
            ph_q <= ph_q + 2'h1;
            if (src_ready) begin
                rd_n <= rd_n + 1;
            end
            if (dst_valid && dst_ready) begin
                wa[wr_n % 8] <= dst_addr;
                wd[wr_n % 8] <= dst_data;
                wr_n <= wr_n + 1;
            end
            if (rd_n - wr_n > fill_max) begin
                fill_max <= rd_n - wr_n;
            end
        end
    end
endmodule

// >>> bench/testbench.sv
// self-checking bench for the dma counter block
`timescale 1ns/1ps
module testbench;
    reg pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0;
    reg [3:0] trig_in = 4'h0;
    reg [15:0] err_at = 16'h0;
    wire [31:0] prdata;
    wire pready, pslverr, src_req, src_ready, src_err, dst_valid, dst_ready;
    wire [23:0] src_addr, dst_addr;
    wire [7:0] src_rdata, dst_data;
    integer err_count = 0, checks = 0, cyc = 0, base, k;
    reg [7:0] rd;
    reg e;
    reg [23:0] v;
    localparam [203:0] ROWS = {8'h14, 8'h01, 1'b0, 8'h15, 8'h00, 1'b0, 8'h16, 8'h00, 1'b0, 8'h18, 8'h00, 1'b0,
        8'h19, 8'h00, 1'b0, 8'h1a, 8'h00, 1'b0, 8'h1c, 8'h00, 1'b0, 8'h1d, 8'h00, 1'b0, 8'h1e, 8'h00, 1'b0,
        8'h05, 8'h00, 1'b1, 8'h17, 8'h00, 1'b1, 8'h4f, 8'h00, 1'b1};
    always #50 pclk = ~pclk;
    dmacr_regs u_dut (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .trig_in(trig_in),
        .src_req(src_req), .src_addr(src_addr), .src_ready(src_ready), .src_err(src_err), .src_rdata(src_rdata),
        .dst_valid(dst_valid), .dst_addr(dst_addr), .dst_data(dst_data), .dst_ready(dst_ready));
    dmacr_mem u_mem (
        .pclk(pclk), .presetn(presetn), .slow(slow), .err_at(err_at), .src_req(src_req), .src_addr(src_addr),
        .src_ready(src_ready), .src_err(src_err), .src_rdata(src_rdata), .dst_valid(dst_valid),
        .dst_addr(dst_addr), .dst_data(dst_data), .dst_ready(dst_ready));
    function [7:0] fx(input [23:0] a);
        fx = a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction
    task test_done;
        begin
            if (err_count == 0 && checks > 0) begin
                $display("TB: PASS");
            end else begin
                $display("TB: FAIL");
            end
            $finish;
        end
    endtask
    task chk(input [23:0] seen, input [23:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("BAD %0t seen %h want %h", $time, seen, exp);
            end
        end
    endtask
    task apb(input [7:0] idx, input w, input [7:0] wd, output [7:0] r, output er);
        integer n;
        begin
            n = 0;
            psel <= 1'b1;
            pwrite <= w;
            paddr <= {2'b00, idx, 2'b00};
            pwdata <= {24'h0, wd};
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1 && n < 20) begin
                @(posedge pclk);
                n = n + 1;
            end
            r = prdata[7:0];
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            chk({23'h0, n == 20}, 24'h0);
            @(posedge pclk);
        end
    endtask
    task wrn(input [7:0] idx, input integer n, input [23:0] val);
        integer i;
        for (i = 0; i < n; i = i + 1) apb(idx + i[7:0], 1'b1, val[8*i +: 8], rd, e);
    endtask
    task rdn(input [7:0] idx, input integer n, output [23:0] val);
        integer i;
        begin
            val = 24'h0;
            for (i = 0; i < n; i = i + 1) begin
                apb(idx + i[7:0], 1'b0, 8'h00, rd, e);
                val[8*i +: 8] = rd;
            end
        end
    endtask
    task waitw(input integer tgt, input integer lim);
        integer n;
        begin
            n = 0;
            while (u_mem.wr_n < tgt && n < lim) begin
                @(posedge pclk);
                n = n + 1;
            end
            repeat (20) @(posedge pclk);
        end
    endtask
    always @(posedge pclk) begin
        cyc = cyc + 1;
        if (cyc == 100000) begin
            err_count = err_count + 1;
            test_done;
        end
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (k = 11; k >= 0; k = k - 1) begin
            apb(ROWS[17*k+9 +: 8], 1'b0, 8'h00, rd, e);
            chk(rd, ROWS[17*k+1 +: 8]);
            chk(e, ROWS[17*k]);
        end
        wrn(8'h44, 2, 24'h000102);
        rdn(8'h44, 2, v);
        chk(v, 24'h000102);
        // one block, source down, dest up, sink stalling
        slow <= 1'b1;
        wrn(8'h00, 1, 24'h80);
        wrn(8'h12, 1, 24'h21);
        wrn(8'h14, 2, 24'h3);
        wrn(8'h18, 3, 24'h123456);
        wrn(8'h1c, 3, 24'h00ff00);
        base = u_mem.wr_n;
        wrn(8'h10, 1, 24'h90);
        waitw(base + 3, 400);
        for (k = 0; k < 3; k = k + 1) begin
            chk(u_mem.wa[(base + k) % 8], 24'h00ff00 + k);
            chk(u_mem.wd[(base + k) % 8], fx(24'h123456 - k));
        end
        chk(u_mem.fill_max, 2);
        rdn(8'h18, 3, v);
        chk(v, 24'h123453);
        rdn(8'h14, 2, v);
        chk(v, 24'h3);
        rdn(8'h03, 1, v);
        chk(v, 24'h1);
        // limited repeat, source held, dest down
        slow <= 1'b0;
        wrn(8'h12, 1, 24'h02);
        wrn(8'h14, 2, 24'h2);
        wrn(8'h16, 1, 24'h2);
        wrn(8'h1c, 3, 24'h10);
        wrn(8'h13, 1, 24'h1);
        trig_in <= 4'h1;
        base = u_mem.wr_n;
        wrn(8'h10, 1, 24'ha0);
        waitw(base + 4, 400);
        chk(u_mem.wr_n - base, 4);
        chk(u_mem.wa[(base + 3) % 8], 24'h0d);
        chk(u_mem.wd[(base + 3) % 8], fx(24'h123453));
        rdn(8'h16, 1, v);
        chk(v, 24'h0);
        rdn(8'h10, 1, v);
        chk(v, 24'h20);
        // unlimited repeat ended by a read error
        wrn(8'h22, 1, 24'h11);
        wrn(8'h24, 2, 24'h1);
        wrn(8'h28, 3, 24'h100);
        wrn(8'h2c, 3, 24'h200);
        wrn(8'h23, 1, 24'h1);
        err_at <= u_mem.rd_n + 7;
        trig_in <= 4'h2;
        base = u_mem.wr_n;
        wrn(8'h20, 1, 24'ha0);
        waitw(base + 6, 400);
        chk(u_mem.wr_n - base, 6);
        chk(u_mem.wa[(base + 5) % 8], 24'h205);
        rdn(8'h03, 1, v);
        chk(v, 24'h23);
        wrn(8'h03, 1, 24'hff);
        trig_in <= 4'h0;
        // zero count runs the full length
        wrn(8'h32, 1, 24'h11);
        wrn(8'h34, 2, 24'h0);
        base = u_mem.wr_n;
        wrn(8'h30, 1, 24'h90);
        waitw(base + 65535, 80000);
        chk(u_mem.wr_n - base, 65535);
        rdn(8'h3c, 3, v);
        chk(v, 24'h00ffff);
        wrn(8'h38, 2, 24'h00bbaa);
        rdn(8'h38, 3, v);
        chk(v, 24'h00ffff);
        // reset with all channels idle brings the counts back to one
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdn(8'h34, 2, v);
        chk(v, 24'h1);
        rdn(8'h3c, 3, v);
        chk(v, 24'h0);
        test_done;
    end
endmodule
